// ### afbm_cfg.svh
// Purpose: constants for the airflow bargraph monitor
// Assumes: 40 MHz system clock
// Notes: percentages are whole percent of the stored reference
`ifndef AFBM_CFG_SVH
`define AFBM_CFG_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define AFBM_CLK_HZ 64'h0000_0000_0262_5A00
`define AFBM_FAULT_DELAY_S 64'h0000_0000_0000_012C
`define AFBM_FLASH_HALF_MS 64'h0000_0000_0000_01F4
`define AFBM_MS_PER_S 64'h0000_0000_0000_03E8
`define AFBM_FAULT_DELAY_CYCLES (`AFBM_FAULT_DELAY_S * `AFBM_CLK_HZ)
`define AFBM_FLASH_HALF_CYCLES \
  ((`AFBM_FLASH_HALF_MS * `AFBM_CLK_HZ) / `AFBM_MS_PER_S)

// ----------------------------------------------------------------------
// scaling
// ----------------------------------------------------------------------
`define AFBM_PCT_FULL 32'h0000_0064
`define AFBM_STEPS 3'h4

// ----------------------------------------------------------------------
// led bar segment positions, bit 9 top
// ----------------------------------------------------------------------
`define AFBM_SEG_MID_HI 4'h5
`define AFBM_SEG_MID_LO 4'h4
`define AFBM_LED_OFF 10'h000
`define AFBM_LED_ONE 10'h001

// ----------------------------------------------------------------------
// band step limits: four upper tops, then four lower bottoms
// ----------------------------------------------------------------------
`define AFBM_B20_UP {8'h69, 8'h6E, 8'h73, 8'h78}
`define AFBM_B20_DN {8'h5F, 8'h5A, 8'h55, 8'h50}
`define AFBM_B10_UP {8'h66, 8'h69, 8'h6B, 8'h6E}
`define AFBM_B10_DN {8'h62, 8'h5F, 8'h5D, 8'h5A}
`define AFBM_B30_UP {8'h6B, 8'h73, 8'h7A, 8'h82}
`define AFBM_B30_DN {8'h5D, 8'h55, 8'h4E, 8'h46}
`define AFBM_B50_UP {8'h70, 8'h7D, 8'h89, 8'h96}
`define AFBM_B50_DN {8'h58, 8'h4B, 8'h3F, 8'h32}

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define AFBM_SW_RESET 2'h0

`endif

// ### afbm_pkg.sv
// Purpose: types for the airflow bargraph monitor
// Assumes: nothing
// Notes: band codes follow the two configuration switches
package afbm_pkg;

  typedef enum logic [1:0] {
    AFBM_BAND_20 = 2'h0,
    AFBM_BAND_10 = 2'h1,
    AFBM_BAND_30 = 2'h2,
    AFBM_BAND_50 = 2'h3
  } afbm_band_t;

  // gray along idle -> pending -> fault
  typedef enum logic [1:0] {
    AFBM_ST_IDLE = 2'h0,
    AFBM_ST_PENDING = 2'h1,
    AFBM_ST_FAULT = 2'h3
  } afbm_state_t;

endpackage

// ### afbm_band_classifier.sv
// Purpose: places the live airflow on the ten segment bar
// Assumes: reference is nonzero when results are used
// Notes: purely combinational, the caller registers the results
`timescale 1ns/100ps
`default_nettype none
`include "afbm_cfg.svh"

module afbm_band_classifier #(
  parameter int SAMPLE_W = 16
) (
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic [SAMPLE_W-1:0] ref_level,
  input wire afbm_pkg::afbm_band_t band,
  output logic [9:0] led_pattern,
  output logic high_oob,
  output logic low_oob
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // compare in scaled form so no divider is needed
  function automatic logic [31:0] scale(input logic [SAMPLE_W-1:0] v,
                                        input logic [31:0] k);
    scale = 32'(v) * k;
  endfunction

  function automatic logic [63:0] limits(input afbm_pkg::afbm_band_t b);
    unique case (b)
      afbm_pkg::AFBM_BAND_20: limits = {`AFBM_B20_UP, `AFBM_B20_DN};
      afbm_pkg::AFBM_BAND_10: limits = {`AFBM_B10_UP, `AFBM_B10_DN};
      afbm_pkg::AFBM_BAND_30: limits = {`AFBM_B30_UP, `AFBM_B30_DN};
      afbm_pkg::AFBM_BAND_50: limits = {`AFBM_B50_UP, `AFBM_B50_DN};
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // step counting
  // ----------------------------------------------------------------------
  wire [63:0] lim = limits(band);
  wire [31:0] live = scale(sample, `AFBM_PCT_FULL);
  wire at_ref = (sample == ref_level);
  wire above_ref = (sample > ref_level);
  logic [3:0] up_hits;
  logic [3:0] dn_hits;
  logic [2:0] up_cnt;
  logic [2:0] dn_cnt;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_step
      assign up_hits[g] = live > scale(ref_level, 32'(lim[63-8*g -: 8]));
      assign dn_hits[g] = live < scale(ref_level, 32'(lim[31-8*g -: 8]));
    end
  endgenerate

  assign up_cnt = 3'(up_hits[0]) + 3'(up_hits[1]) + 3'(up_hits[2])
                + 3'(up_hits[3]);
  assign dn_cnt = 3'(dn_hits[0]) + 3'(dn_hits[1]) + 3'(dn_hits[2])
                + 3'(dn_hits[3]);

  // ----------------------------------------------------------------------
  // bar pattern: 9 yellow high, 8..5 green up, 4..1 green down, 0 yellow
  // ----------------------------------------------------------------------
  wire [3:0] up_seg = `AFBM_SEG_MID_HI + 4'(up_cnt);
  wire [3:0] dn_seg = `AFBM_SEG_MID_LO - 4'(dn_cnt);
  wire [9:0] mid_pair = (`AFBM_LED_ONE << `AFBM_SEG_MID_HI)
                      | (`AFBM_LED_ONE << `AFBM_SEG_MID_LO);

  assign led_pattern = at_ref ? mid_pair :                      // [R2]
                       above_ref ? (`AFBM_LED_ONE << up_seg) :  // [R3] [R4]
                       (`AFBM_LED_ONE << dn_seg);               // [R3] [R4]
  assign high_oob = above_ref && up_cnt == `AFBM_STEPS;         // [R5]
  assign low_oob = !above_ref && dn_cnt == `AFBM_STEPS;         // [R5]

endmodule

`default_nettype wire

// ### afbm_airflow_bargraph_monitor.sv
// Purpose: airflow supervision with led bar and delayed airflow fault
// Assumes: capture pulse and samples come from logic on clk
// Notes: switch pins are synchronised before use
//
// Contract
// R1: at initial reset completion, store current airflow as 100% reference; the code stores it on every init_capture pulse instead
// R2: airflow equal to reference lights exactly the two centre segments
// R3: in-tolerance deviation lights one green segment of its band step
// R4: beyond tolerance lights yellow: top for excess, bottom for too little
// R5: below reference is blockage, above is breakage: low and high flags
// R6: four bands of 10, 20, 30 and 50 percent set the limits
// R7: both switches off select 20 percent; fault after 300 s out of band
// R8: fault indicator flashes while the delay runs
// R9: return within tolerance cancels pending fault and restarts delay
`timescale 1ns/100ps
`default_nettype none
`include "afbm_cfg.svh"

module afbm_airflow_bargraph_monitor #(
  parameter int SAMPLE_W = 16,
  parameter int DELAY_W = 34,
  parameter logic [DELAY_W-1:0] FAULT_DELAY_CYCLES =
    DELAY_W'(`AFBM_FAULT_DELAY_CYCLES),
  parameter int FLASH_W = 25,
  parameter logic [FLASH_W-1:0] FLASH_HALF_CYCLES =
    FLASH_W'(`AFBM_FLASH_HALF_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SAMPLE_W-1:0] airflow_sample,
  input wire logic airflow_valid,
  input wire logic init_capture,
  input wire logic [1:0] airflow_cfg_sw,
  output logic [9:0] led_bar,
  output logic fault_led,
  output logic airflow_fault,
  output logic airflow_high_out_of_band,
  output logic airflow_low_out_of_band,
  output logic ref_valid
);

  // ----------------------------------------------------------------------
  // switch synchroniser
  // ----------------------------------------------------------------------
  logic [1:0] sw_meta_ff;
  logic [1:0] sw_sync_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_meta_ff <= `AFBM_SW_RESET;
      sw_sync_ff <= `AFBM_SW_RESET;
    end else begin
      sw_meta_ff <= airflow_cfg_sw;
      sw_sync_ff <= sw_meta_ff;
    end
  end

  // both switches off map to code zero, the 20 percent band
  afbm_pkg::afbm_band_t band;
  assign band = afbm_pkg::afbm_band_t'(sw_sync_ff); // [R6] [R7]

  // ----------------------------------------------------------------------
  // reference capture and live sample
  // ----------------------------------------------------------------------
  logic [SAMPLE_W-1:0] ref_ff;
  logic [SAMPLE_W-1:0] nxt_ref;
  logic [SAMPLE_W-1:0] sample_ff;
  logic [SAMPLE_W-1:0] nxt_sample;
  logic ref_valid_ff;
  logic nxt_ref_valid;

  // the captured sample is also the live value so the bar shows 100%
  assign nxt_ref = init_capture ? airflow_sample : ref_ff; // [R1]
  assign nxt_sample = (init_capture || airflow_valid) ?
                      airflow_sample : sample_ff;
  assign nxt_ref_valid = ref_valid_ff || init_capture;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_ff <= '0;
      sample_ff <= '0;
      ref_valid_ff <= 1'b0;
    end else begin
      ref_ff <= nxt_ref;
      sample_ff <= nxt_sample;
      ref_valid_ff <= nxt_ref_valid;
    end
  end

  // ----------------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------------
  logic [9:0] pattern;
  logic high_raw;
  logic low_raw;

  afbm_band_classifier #(
    .SAMPLE_W(SAMPLE_W)
  ) u_classifier (
    .sample(sample_ff),
    .ref_level(ref_ff),
    .band(band),
    .led_pattern(pattern),
    .high_oob(high_raw),
    .low_oob(low_raw)
  );

  // nothing is judged until a reference exists
  // capture cycle reads 100%, so flags agree with the forced centre pair
  wire high_oob = ref_valid_ff && high_raw && !init_capture; // [R5]
  wire low_oob = ref_valid_ff && low_raw && !init_capture;   // [R5]
  wire out_of_band = high_oob || low_oob;

  // ----------------------------------------------------------------------
  // fault delay state machine
  // ----------------------------------------------------------------------
  afbm_pkg::afbm_state_t state_ff;
  afbm_pkg::afbm_state_t nxt_state;
  logic [DELAY_W-1:0] delay_cnt_ff;
  logic [DELAY_W-1:0] nxt_delay_cnt;

  wire delay_done = delay_cnt_ff == FAULT_DELAY_CYCLES - DELAY_W'(1);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      afbm_pkg::AFBM_ST_IDLE: begin
        if (out_of_band) begin
          nxt_state = afbm_pkg::AFBM_ST_PENDING; // [R8]
        end
      end
      afbm_pkg::AFBM_ST_PENDING: begin
        if (!out_of_band) begin
          nxt_state = afbm_pkg::AFBM_ST_IDLE; // [R9]
        end else if (delay_done) begin
          nxt_state = afbm_pkg::AFBM_ST_FAULT; // [R7]
        end
      end
      afbm_pkg::AFBM_ST_FAULT: begin
        if (!out_of_band) begin
          nxt_state = afbm_pkg::AFBM_ST_IDLE;
        end
      end
      default: begin
        nxt_state = afbm_pkg::AFBM_ST_IDLE;
      end
    endcase
  end

  // counter only runs while pending, so each excursion starts from zero
  assign nxt_delay_cnt = (nxt_state == afbm_pkg::AFBM_ST_PENDING &&
                          state_ff == afbm_pkg::AFBM_ST_PENDING) ?
                         delay_cnt_ff + DELAY_W'(1) : '0; // [R9]

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= afbm_pkg::AFBM_ST_IDLE;
      delay_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      delay_cnt_ff <= nxt_delay_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // flash timer
  // ----------------------------------------------------------------------
  logic [FLASH_W-1:0] flash_cnt_ff;
  logic [FLASH_W-1:0] nxt_flash_cnt;
  logic flash_phase_ff;
  logic nxt_flash_phase;

  wire pending_next = nxt_state == afbm_pkg::AFBM_ST_PENDING;
  wire flash_wrap = flash_cnt_ff == FLASH_HALF_CYCLES - FLASH_W'(1);

  // phase restarts lit on each excursion so the first flash is visible
  assign nxt_flash_cnt = (!pending_next || flash_wrap) ?
                         '0 : flash_cnt_ff + FLASH_W'(1);
  assign nxt_flash_phase = !pending_next ? 1'b1 :
                           flash_wrap ? !flash_phase_ff : flash_phase_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      flash_cnt_ff <= '0;
      flash_phase_ff <= 1'b1;
    end else begin
      flash_cnt_ff <= nxt_flash_cnt;
      flash_phase_ff <= nxt_flash_phase;
    end
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  logic [9:0] led_bar_ff;
  logic fault_led_ff;
  logic airflow_fault_ff;
  logic high_ff;
  logic low_ff;
  logic [9:0] nxt_led_bar;
  logic nxt_fault_led;
  logic nxt_fault;

  assign nxt_led_bar = nxt_ref_valid ?
                       (init_capture ?
                        ((`AFBM_LED_ONE << `AFBM_SEG_MID_HI) |
                         (`AFBM_LED_ONE << `AFBM_SEG_MID_LO)) :
                        pattern) : `AFBM_LED_OFF; // [R2] [R3] [R4]
  assign nxt_fault = nxt_state == afbm_pkg::AFBM_ST_FAULT; // [R7]
  // steady once the fault is reported, flashing while the delay runs
  assign nxt_fault_led = nxt_fault ||
                         (pending_next && nxt_flash_phase); // [R8]

  always_ff @(posedge clk) begin
    if (rst) begin
      led_bar_ff <= `AFBM_LED_OFF;
      fault_led_ff <= 1'b0;
      airflow_fault_ff <= 1'b0;
      high_ff <= 1'b0;
      low_ff <= 1'b0;
    end else begin
      led_bar_ff <= nxt_led_bar;
      fault_led_ff <= nxt_fault_led;
      airflow_fault_ff <= nxt_fault;
      high_ff <= high_oob;
      low_ff <= low_oob;
    end
  end

  assign led_bar = led_bar_ff;
  assign fault_led = fault_led_ff;
  assign airflow_fault = airflow_fault_ff;
  assign airflow_high_out_of_band = high_ff;
  assign airflow_low_out_of_band = low_ff;
  assign ref_valid = ref_valid_ff;

endmodule

`default_nettype wire

// ### afbm_monitor_asserts.sv
// Purpose: port checks for the airflow bargraph monitor
// Assumes: one clock, sync reset rst, flash half period of at most 4 cycles
// Notes: fault delay figure handed in as a parameter
`timescale 1ns/100ps
`default_nettype none
module afbm_monitor_asserts #(
  parameter int SAMPLE_W = 16,
  parameter int DELAY_W = 34,
  parameter logic [DELAY_W-1:0] FAULT_DELAY_CYCLES = 34'h0_0000_0014
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SAMPLE_W-1:0] airflow_sample,
  input wire logic airflow_valid,
  input wire logic init_capture,
  input wire logic [1:0] airflow_cfg_sw,
  input wire logic [9:0] led_bar,
  input wire logic fault_led,
  input wire logic airflow_fault,
  input wire logic airflow_high_out_of_band,
  input wire logic airflow_low_out_of_band,
  input wire logic ref_valid
);
  // ------------------------------------------------------------
  // cycles spent out of band
  // ------------------------------------------------------------
  logic oob;
  logic [DELAY_W-1:0] oob_cnt_ff;
  assign oob = airflow_high_out_of_band | airflow_low_out_of_band;
  always_ff @(posedge clk) begin
    oob_cnt_ff <= (rst || !oob) ? '0 : oob_cnt_ff + 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_CAPTURE: assert property (
    init_capture |=> ref_valid && led_bar == 10'h030)
    else $error("capture did not light the centre pair");
  AST_NO_REF: assert property (
    !ref_valid |-> led_bar == 10'h000 && !oob && !airflow_fault)
    else $error("output active without a reference");
  AST_BAR_SHAPE: assert property (
    ref_valid |-> led_bar == 10'h030 || $onehot(led_bar))
    else $error("bar shows neither centre pair nor one segment");
  AST_HIGH: assert property (
    ref_valid |-> airflow_high_out_of_band == led_bar[9])
    else $error("high flag and top segment disagree");
  AST_LOW: assert property (
    ref_valid |-> airflow_low_out_of_band == led_bar[0])
    else $error("low flag and bottom segment disagree");
  AST_ONE_DIR: assert property (
    !(airflow_high_out_of_band && airflow_low_out_of_band))
    else $error("both directions flagged");
  AST_FAULT_TIME: assert property (
    $rose(airflow_fault) |-> oob_cnt_ff >= FAULT_DELAY_CYCLES &&
      oob_cnt_ff <= FAULT_DELAY_CYCLES + 2)
    else $error("fault rose at the wrong delay");
  AST_FAULT_STEADY: assert property (
    airflow_fault |-> fault_led)
    else $error("indicator dark while in fault");
  AST_FLASH_LIT: assert property (
    (oob && !airflow_fault && fault_led)[*5] |-> 1'b0)
    else $error("indicator not flashing while delay runs");
  AST_FLASH_DARK: assert property (
    (oob && !airflow_fault && !fault_led)[*5] |-> 1'b0)
    else $error("indicator stuck dark while delay runs");
  AST_IDLE_DARK: assert property (
    (!oob)[*2] |-> !fault_led && !airflow_fault)
    else $error("fault kept after return in band");
  cover property ($rose(airflow_fault));
  cover property ($rose(airflow_high_out_of_band));
  cover property ($rose(airflow_low_out_of_band));
  cover property (init_capture);
endmodule
bind afbm_airflow_bargraph_monitor afbm_monitor_asserts #(
  .SAMPLE_W(SAMPLE_W), .DELAY_W(DELAY_W),
  .FAULT_DELAY_CYCLES(FAULT_DELAY_CYCLES)
) afbm_monitor_asserts_i (
  .clk(clk), .rst(rst), .airflow_sample(airflow_sample),
  .airflow_valid(airflow_valid), .init_capture(init_capture),
  .airflow_cfg_sw(airflow_cfg_sw), .led_bar(led_bar),
  .fault_led(fault_led), .airflow_fault(airflow_fault),
  .airflow_high_out_of_band(airflow_high_out_of_band),
  .airflow_low_out_of_band(airflow_low_out_of_band),
  .ref_valid(ref_valid)
);
`default_nettype wire

// ### afbm_sensor_model.sv
// Purpose: airflow sensor, one measurement every gap+1 cycles
// Assumes: level driven by the bench
// Notes: between measurements the value is junk, not held
`timescale 1ns/100ps
`default_nettype none
module afbm_sensor_model (
  input wire logic clk,
  input wire logic [15:0] level,
  input wire logic [1:0] gap,
  output logic [15:0] airflow_sample,
  output logic airflow_valid
);
  logic [1:0] wait_cnt;
  initial begin
    airflow_sample = 16'h0000;
    airflow_valid = 1'b0;
    wait_cnt = 2'h0;
  end
  // inverted level off the strobe, so stale data is never taken
  always @(negedge clk) begin
    airflow_valid <= (wait_cnt == gap);
    airflow_sample <= (wait_cnt == gap) ? level : ~level;
    wait_cnt <= (wait_cnt == gap) ? 2'h0 : wait_cnt + 2'h1;
  end
endmodule
`default_nettype wire

// ### tb_airflow_bargraph_monitor.sv
// Purpose: self-checking bench for the airflow bargraph monitor
// Assumes: fault delay shortened to 20 cycles, flash half period 3
// Notes: references are multiples of 100 so percents are exact
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) check_val(64'(a), 64'(e))
module tb_airflow_bargraph_monitor;
  localparam int N = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic init_capture = 1'b0;
  logic [1:0] airflow_cfg_sw = 2'h0;
  logic [15:0] level = 16'h0000;
  logic [1:0] gap = 2'h0;
  logic [15:0] airflow_sample;
  logic airflow_valid;
  logic [9:0] led_bar;
  logic fault_led, airflow_fault, hi_oob, lo_oob, ref_valid;
  int num_errors = 0;
  int total_checks = 0;
  int ref_lvl, n, tog;
  int pcts[20] = '{100, 101, 105, 106, 110, 111, 115, 116, 120, 121,
    99, 95, 94, 90, 89, 85, 84, 80, 79, 50};
  always #12.5 clk = ~clk;
  afbm_sensor_model afbm_sensor_model_i (.clk(clk), .level(level),
    .gap(gap), .airflow_sample(airflow_sample),
    .airflow_valid(airflow_valid));
  afbm_airflow_bargraph_monitor #(.FAULT_DELAY_CYCLES(34'h0_0000_0014),
    .FLASH_HALF_CYCLES(25'h000_0003)) afbm_airflow_bargraph_monitor_i (
    .clk(clk), .rst(rst), .airflow_sample(airflow_sample),
    .airflow_valid(airflow_valid), .init_capture(init_capture),
    .airflow_cfg_sw(airflow_cfg_sw), .led_bar(led_bar),
    .fault_led(fault_led), .airflow_fault(airflow_fault),
    .airflow_high_out_of_band(hi_oob), .airflow_low_out_of_band(lo_oob),
    .ref_valid(ref_valid));
  // ------------------------------------------------------------
  // checking and helpers
  // ------------------------------------------------------------
  task automatic check_val(input logic [63:0] a, input logic [63:0] e);
    total_checks++;
    if (a !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // band index follows the switch code: 20, 10, 30, 50 percent
  function automatic logic [9:0] exp_bar(input int s, r, b);
    int up[4][4] = '{'{105, 110, 115, 120}, '{102, 105, 107, 110},
      '{107, 115, 122, 130}, '{112, 125, 137, 150}};
    int dn[4][4] = '{'{95, 90, 85, 80}, '{98, 95, 93, 90},
      '{93, 85, 78, 70}, '{88, 75, 63, 50}};
    int k = 0;
    if (s == r) return 10'h030;
    for (int i = 0; i < 4; i++) begin
      if (s > r) k += int'(s * 100 > r * up[b][i]);
      else k += int'(s * 100 < r * dn[b][i]);
    end
    return (s > r) ? 10'h020 << k : 10'h010 >> k;
  endfunction
  task automatic show(input int p);
    logic [9:0] e;
    e = exp_bar(ref_lvl * p / 100, ref_lvl, int'(airflow_cfg_sw));
    level <= 16'(ref_lvl * p / 100);
    gap <= 2'($urandom_range(0, 3));
    cyc(12);
    `CHK(led_bar, e);
    `CHK({hi_oob, lo_oob}, {e[9], e[0]});
  endtask
  task automatic capture(input int r);
    gap <= 2'h0;
    level <= 16'(r);
    // a shorter gap only takes hold once the model's counter wraps
    cyc(5);
    init_capture <= 1'b1;
    cyc(1);
    init_capture <= 1'b0;
    ref_lvl = r;
    `CHK({ref_valid, led_bar}, {1'b1, 10'h030});
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    level <= 16'h0bb8;
    cyc(6);
    rst <= 1'b0;
    cyc(8);
    `CHK({ref_valid, led_bar, airflow_fault}, 12'h000);
    $display("reset test done");
  endtask
  task automatic wait_fault(input int lim);
    logic prev;
    n = 0;
    tog = 0;
    prev = fault_led;
    while (airflow_fault !== 1'b1) begin
      cyc(1);
      n++;
      if (fault_led !== prev) tog++;
      prev = fault_led;
      if (n >= lim) begin
        num_errors++;
        final_report();
      end
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    n = $urandom(32'h6ff7_1e17);
    do_reset();
    for (int b = 0; b < 4; b++) begin
      airflow_cfg_sw <= 2'(b);
      capture(100 * $urandom_range(10, 40));
      foreach (pcts[i]) show(pcts[i]);
      repeat (10) show($urandom_range(40, 160));
      $display("band %0d test done", b);
    end
    airflow_cfg_sw <= 2'h0;
    capture(2000);
    show(70);
    show(100);
    `CHK({airflow_fault, fault_led}, 2'h0);
    level <= 16'h0a28;
    wait_fault(60);
    `CHK(n > N && n <= N + 6, 1'b1);
    `CHK(tog >= 3, 1'b1);
    `CHK({airflow_fault, fault_led, hi_oob, lo_oob}, 4'he);
    show(100);
    `CHK({airflow_fault, fault_led}, 2'h0);
    $display("fault delay test done");
    capture(1500);
    capture(3000);
    show(50);
    do_reset();
    final_report();
  end
endmodule
`default_nettype wire
